// ### pcpc_chk.sv
// port-level assertions for the pll clock path control block.
// assumes one clock and an async active-low reset; bound below.
`timescale 1ns/100ps
`default_nettype none
module pcpc_chk #(
  parameter CAL_CYCLES = 8
) (
  input wire logic        CLK_IN,
  input wire logic        RSTN_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic        PREADY_OUT,
  input wire logic        PSLVERR_OUT,
  input wire logic        PLL_ON_OUT,
  input wire logic        PLL_PWRDN_OUT,
  input wire logic        SRC_INT_VCO_OUT,
  input wire logic        SRC_EXT_CLK_OUT,
  input wire logic        PFD_POL_NEG_OUT,
  input wire logic [1:0]  ANTIBACKLASH_OUT,
  input wire logic        CP_HIGHZ_OUT,
  input wire logic        CP_NORMAL_OUT,
  input wire logic        CP_PUMP_UP_OUT,
  input wire logic        CP_PUMP_DN_OUT,
  input wire logic [2:0]  CP_CURRENT_OUT,
  input wire logic        VCO_CAL_BUSY_OUT
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RSTN_IN);
  wire         commit_w = PSEL_IN && PENABLE_IN && PWRITE_IN &&
                          PADDR_IN == 12'h8c8 && PWDATA_IN[7:0] == 8'h01;
  logic [15:0] run_r;
  // counts busy cycles so a long run needs no repetition
  always @(posedge CLK_IN or negedge RSTN_IN)
    if (!RSTN_IN)
      run_r <= 16'h0;
    else
      run_r <= VCO_CAL_BUSY_OUT ? run_r + 16'h1 : 16'h0;
  sequence s_commit;
    commit_w;
  endsequence
  a_pwrdn_inverse: assert property (PLL_PWRDN_OUT != PLL_ON_OUT)
    else $error("power down not inverse of pll on");
  a_src_exclusive: assert property (SRC_EXT_CLK_OUT != SRC_INT_VCO_OUT)
    else $error("source selects not exclusive");
  a_pol_internal: assert property (SRC_INT_VCO_OUT |-> !PFD_POL_NEG_OUT)
    else $error("polarity active with on-chip oscillator");
  a_cp_onehot: assert property ($onehot({CP_HIGHZ_OUT, CP_NORMAL_OUT,
    CP_PUMP_UP_OUT, CP_PUMP_DN_OUT}))
    else $error("charge pump mode not one-hot");
  a_ready_high: assert property (PREADY_OUT)
    else $error("ready low");
  a_slverr_access: assert property (PSLVERR_OUT |-> PSEL_IN && PENABLE_IN)
    else $error("error outside access phase");
  a_commit_only: assert property (!$past(commit_w) |=> $stable({PLL_ON_OUT,
    SRC_INT_VCO_OUT, PFD_POL_NEG_OUT, ANTIBACKLASH_OUT, CP_CURRENT_OUT,
    CP_NORMAL_OUT}))
    else $error("active setting changed without commit");
  a_cal_start: assert property ($rose(VCO_CAL_BUSY_OUT) |-> $past(commit_w, 2))
    else $error("calibration started without commit");
  a_cal_hold: assert property (s_commit ##2 $rose(VCO_CAL_BUSY_OUT)
    |-> VCO_CAL_BUSY_OUT[*4])
    else $error("calibration ended early");
  a_cal_length: assert property ($fell(VCO_CAL_BUSY_OUT) |->
    run_r == CAL_CYCLES)
    else $error("calibration run length wrong");
endmodule // pcpc_chk
bind pcpc_top pcpc_chk #(.CAL_CYCLES(CAL_CYCLES)) u_pcpc_chk (.CLK_IN(CLK_IN),
  .RSTN_IN(RSTN_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
  .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
  .PLL_ON_OUT(PLL_ON_OUT), .PLL_PWRDN_OUT(PLL_PWRDN_OUT),
  .SRC_INT_VCO_OUT(SRC_INT_VCO_OUT), .SRC_EXT_CLK_OUT(SRC_EXT_CLK_OUT),
  .PFD_POL_NEG_OUT(PFD_POL_NEG_OUT), .ANTIBACKLASH_OUT(ANTIBACKLASH_OUT),
  .CP_HIGHZ_OUT(CP_HIGHZ_OUT), .CP_NORMAL_OUT(CP_NORMAL_OUT),
  .CP_PUMP_UP_OUT(CP_PUMP_UP_OUT), .CP_PUMP_DN_OUT(CP_PUMP_DN_OUT),
  .CP_CURRENT_OUT(CP_CURRENT_OUT), .VCO_CAL_BUSY_OUT(VCO_CAL_BUSY_OUT));
`default_nettype wire

// ### pcpc_defs.vh
// register map, field positions, reset values and codes for the
// pll clock path control block; included by the design file only.
`ifndef PCPC_DEFS_VH
`define PCPC_DEFS_VH

// register indices; byte address is four times the index
`define PCPC_IDX_PLL_CTRL     10'h010
`define PCPC_IDX_PFD_PULSE    10'h017
`define PCPC_IDX_VCO_CAL      10'h018
`define PCPC_IDX_CP_CURRENT   10'h0f0
`define PCPC_IDX_STATUS       10'h0f1
`define PCPC_IDX_SRC_SEL      10'h1e1
`define PCPC_IDX_UPDATE       10'h232

// apb address split
`define PCPC_AW               12
`define PCPC_IDX_MSB          11
`define PCPC_IDX_LSB          2
`define PCPC_BYTE_MSB         1

// pll control fields
`define PCPC_PWR_MSB          1
`define PCPC_PWR_LSB          0
`define PCPC_CPM_MSB          6
`define PCPC_CPM_LSB          4
`define PCPC_POL_BIT          7
`define PCPC_PWR_ON           2'h0
`define PCPC_PWR_ASYNC_DN     2'h1

// charge pump mode codes
`define PCPC_CPM_HIGHZ        3'h0
`define PCPC_CPM_UP           3'h1
`define PCPC_CPM_DN           3'h2
`define PCPC_CPM_NORMAL       3'h3

// antibacklash, source select, calibration, current fields
`define PCPC_ABL_MSB          1
`define PCPC_ABL_LSB          0
`define PCPC_BYP_BIT          0
`define PCPC_SRC_BIT          1
`define PCPC_CAL_BIT          0
`define PCPC_CPI_MSB          2
`define PCPC_CPI_LSB          0

// status bits
`define PCPC_ST_PLL_ON        0
`define PCPC_ST_CAL_BUSY      1
`define PCPC_ST_CAL_DONE      2
`define PCPC_ST_CAL_ERR       3
`define PCPC_ST_REF_OK        4
`define PCPC_ST_INT_VCO       5

// reset values and the commit key
`define PCPC_RST_PLL_CTRL     8'h01
`define PCPC_RST_PFD_PULSE    8'h00
`define PCPC_RST_VCO_CAL      8'h00
`define PCPC_RST_CP_CURRENT   8'h07
`define PCPC_RST_SRC_SEL      8'h00
`define PCPC_UPDATE_KEY       8'h01

`endif

// ### pcpc_top.v
// pll clock path control: apb register file with staged and active
// copies, source routing, pfd and charge pump controls, vco calibration
// sequencer. assumes a 25 MHz apb clock and an asynchronous ref pin.
//
// Overview of operation
// - loop power field 01b powers loop down asynchronously, 00b runs it.
// - divider bypass bit 1 feeds distribution straight from selected source.
// - source select bit 0 routes the external clock input to distribution.
// - polarity bit 0 positive, 1 negative tuning slope.
// - polarity matters only with external oscillator; ignored for on-chip one.
// - writing 0x01 to the update register commits all programmed values.
// - two-bit antibacklash field sets phase detector delay pulse width.
// - charge pump mode: high impedance, normal, forced up, forced down.
// - charge pump current has eight steps, top step nominally 4.8 mA.
// - source select bit 1 routes the on-chip oscillator to distribution.
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "pcpc_defs.vh"

module pcpc_top #(
  parameter CAL_CYCLES = 256
) (
  input  wire                 CLK_IN,
  input  wire                 RSTN_IN,
  input  wire                 PSEL_IN,
  input  wire                 PENABLE_IN,
  input  wire                 PWRITE_IN,
  input  wire [`PCPC_AW-1:0]  PADDR_IN,
  input  wire [31:0]          PWDATA_IN,
  output reg  [31:0]          PRDATA_OUT,
  output wire                 PREADY_OUT,
  output wire                 PSLVERR_OUT,
  input  wire                 REF_PRESENT_IN,
  output reg                  PLL_ON_OUT,
  output reg                  PLL_PWRDN_OUT,
  output reg                  DIV_BYPASS_OUT,
  output reg                  SRC_INT_VCO_OUT,
  output reg                  SRC_EXT_CLK_OUT,
  output reg                  PFD_POL_NEG_OUT,
  output reg  [1:0]           ANTIBACKLASH_OUT,
  output reg                  CP_HIGHZ_OUT,
  output reg                  CP_NORMAL_OUT,
  output reg                  CP_PUMP_UP_OUT,
  output reg                  CP_PUMP_DN_OUT,
  output reg  [2:0]           CP_CURRENT_OUT,
  output reg                  VCO_CAL_BUSY_OUT
);

  localparam ST_IDLE = 2'h0;
  localparam ST_RUN  = 2'h1;
  localparam ST_DONE = 2'h2;

  // staged copies written by software
  reg  [7:0]  pll_ctrl_r;
  reg  [7:0]  pfd_pulse_r;
  reg  [7:0]  vco_cal_r;
  reg  [7:0]  cp_current_r;
  reg  [7:0]  src_sel_r;
  // active copies steering the hardware
  reg  [7:0]  act_pll_ctrl_r;
  reg  [7:0]  act_pfd_pulse_r;
  reg  [7:0]  act_vco_cal_r;
  reg  [7:0]  act_cp_current_r;
  reg  [7:0]  act_src_sel_r;
  reg         cal_prev_r;
  reg  [1:0]  cal_state_r;
  reg  [1:0]  cal_state_nxt;
  reg  [15:0] cal_cnt_r;
  reg  [15:0] cal_cnt_nxt;
  reg         cal_err_r;
  reg         cal_err_nxt;
  reg  [2:0]  ref_sync_r;
  reg         ref_ok_r;
  reg  [7:0]  rd_mux;
  reg         hit;
  // next values of the hardware control outputs
  reg         pll_on_nxt;
  reg         pll_pwrdn_nxt;
  reg         div_bypass_nxt;
  reg         src_int_nxt;
  reg         src_ext_nxt;
  reg         pol_neg_nxt;
  reg  [1:0]  abl_nxt;
  reg         cp_highz_nxt;
  reg         cp_normal_nxt;
  reg         cp_up_nxt;
  reg         cp_dn_nxt;
  reg  [2:0]  cp_current_nxt;

  wire [9:0]  idx      = PADDR_IN[`PCPC_IDX_MSB:`PCPC_IDX_LSB];
  wire        aligned  = (PADDR_IN[`PCPC_BYTE_MSB:0] == 2'h0);
  wire        setup_ph = PSEL_IN & ~PENABLE_IN;
  wire        access   = PSEL_IN & PENABLE_IN;
  wire        wr_en    = access & PWRITE_IN & hit;
  wire        commit   = wr_en & (idx == `PCPC_IDX_UPDATE) &
                         (PWDATA_IN[7:0] == `PCPC_UPDATE_KEY);
  wire        cal_rise = act_vco_cal_r[`PCPC_CAL_BIT] & ~cal_prev_r;
  wire [31:0] cal_span = CAL_CYCLES - 1;
  wire [15:0] cal_last = cal_span[15:0];
  wire [2:0]  cp_mode  = act_pll_ctrl_r[`PCPC_CPM_MSB:`PCPC_CPM_LSB];
  wire        int_vco  = act_src_sel_r[`PCPC_SRC_BIT];

  // zero wait states; unmapped or unaligned accesses end in error
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = access & ~hit;

  // address decode and read mux
  always @*
  begin
    hit    = aligned;
    rd_mux = 8'h00;
    case (idx)
      `PCPC_IDX_PLL_CTRL:   rd_mux = pll_ctrl_r;
      `PCPC_IDX_PFD_PULSE:  rd_mux = pfd_pulse_r;
      `PCPC_IDX_VCO_CAL:    rd_mux = vco_cal_r;
      `PCPC_IDX_CP_CURRENT: rd_mux = cp_current_r;
      `PCPC_IDX_SRC_SEL:    rd_mux = src_sel_r;
      `PCPC_IDX_UPDATE:     rd_mux = 8'h00;
      `PCPC_IDX_STATUS:
      begin
        rd_mux[`PCPC_ST_PLL_ON]   = PLL_ON_OUT;
        rd_mux[`PCPC_ST_CAL_BUSY] = (cal_state_r == ST_RUN);
        rd_mux[`PCPC_ST_CAL_DONE] = (cal_state_r == ST_DONE);
        rd_mux[`PCPC_ST_CAL_ERR]  = cal_err_r;
        rd_mux[`PCPC_ST_REF_OK]   = ref_ok_r;
        rd_mux[`PCPC_ST_INT_VCO]  = int_vco;
      end
      default:              hit = 1'b0;
    endcase
  end

  // read data captured in the setup cycle so it is stable at access
  always @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      PRDATA_OUT <= 32'h0000_0000;
    else if (setup_ph & ~PWRITE_IN)
      PRDATA_OUT <= {24'h00_0000, (hit ? rd_mux : 8'h00)};
  end

  // staged register writes; status and update read-only or self-clearing
  always @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      pll_ctrl_r   <= `PCPC_RST_PLL_CTRL;
      pfd_pulse_r  <= `PCPC_RST_PFD_PULSE;
      vco_cal_r    <= `PCPC_RST_VCO_CAL;
      cp_current_r <= `PCPC_RST_CP_CURRENT;
      src_sel_r    <= `PCPC_RST_SRC_SEL;
    end
    else if (wr_en)
    begin
      case (idx)
        `PCPC_IDX_PLL_CTRL:   pll_ctrl_r   <= PWDATA_IN[7:0];
        `PCPC_IDX_PFD_PULSE:  pfd_pulse_r  <= PWDATA_IN[7:0];
        `PCPC_IDX_VCO_CAL:    vco_cal_r    <= PWDATA_IN[7:0];
        `PCPC_IDX_CP_CURRENT: cp_current_r <= PWDATA_IN[7:0];
        `PCPC_IDX_SRC_SEL:    src_sel_r    <= PWDATA_IN[7:0];
        default:              pll_ctrl_r   <= pll_ctrl_r;
      endcase
    end
  end

  // staged values reach hardware only on the commit key
  always @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      act_pll_ctrl_r   <= `PCPC_RST_PLL_CTRL;
      act_pfd_pulse_r  <= `PCPC_RST_PFD_PULSE;
      act_vco_cal_r    <= `PCPC_RST_VCO_CAL;
      act_cp_current_r <= `PCPC_RST_CP_CURRENT;
      act_src_sel_r    <= `PCPC_RST_SRC_SEL;
    end
    else if (commit)
    begin
      act_pll_ctrl_r   <= pll_ctrl_r;
      act_pfd_pulse_r  <= pfd_pulse_r;
      act_vco_cal_r    <= vco_cal_r;
      act_cp_current_r <= cp_current_r;
      act_src_sel_r    <= src_sel_r;
    end
  end

  // reference pin: three stages, change accepted once stages 2 and 3 agree
  always @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      ref_sync_r <= 3'h0;
      ref_ok_r   <= 1'b0;
    end
    else
    begin
      ref_sync_r <= {ref_sync_r[1:0], REF_PRESENT_IN};
      if (ref_sync_r[1] == ref_sync_r[2])
        ref_ok_r <= ref_sync_r[2];
    end
  end

  // calibration starts only on a committed 0 to 1 of the calibration bit,
  // so a repeat needs a committed clear first
  always @*
  begin
    cal_state_nxt = cal_state_r;
    cal_cnt_nxt   = cal_cnt_r;
    cal_err_nxt   = cal_err_r;
    case (cal_state_r)
      ST_IDLE,
      ST_DONE:
      begin
        if (cal_rise)
        begin
          cal_state_nxt = ST_RUN;
          cal_cnt_nxt   = 16'h0000;
          cal_err_nxt   = 1'b0;
        end
      end
      ST_RUN:
      begin
        // a missing reference spoils the result; flagged, not retried
        if (!ref_ok_r)
          cal_err_nxt = 1'b1;
        if (cal_cnt_r == cal_last)
          cal_state_nxt = ST_DONE;
        else
          cal_cnt_nxt = cal_cnt_r + 16'h0001;
      end
      default:
        cal_state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      cal_prev_r  <= 1'b0;
      cal_state_r <= ST_IDLE;
      cal_cnt_r   <= 16'h0000;
      cal_err_r   <= 1'b0;
    end
    else
    begin
      cal_prev_r  <= act_vco_cal_r[`PCPC_CAL_BIT];
      cal_state_r <= cal_state_nxt;
      cal_cnt_r   <= cal_cnt_nxt;
      cal_err_r   <= cal_err_nxt;
    end
  end

  // output decode from the active copies; registered below
  always @*
  begin
    // other power codes leave the loop off as the safe choice
    pll_on_nxt     = (act_pll_ctrl_r[`PCPC_PWR_MSB:`PCPC_PWR_LSB] ==
                      `PCPC_PWR_ON);
    pll_pwrdn_nxt  = ~pll_on_nxt;
    div_bypass_nxt = act_src_sel_r[`PCPC_BYP_BIT];
    src_int_nxt    = int_vco;
    src_ext_nxt    = ~int_vco;
    pol_neg_nxt    = 1'b0;
    if (int_vco)
    begin
      // on-chip oscillator has a fixed slope, so polarity is masked
      pol_neg_nxt = 1'b0;
    end
    else
    begin
      pol_neg_nxt = act_pll_ctrl_r[`PCPC_POL_BIT];
    end
    abl_nxt        = act_pfd_pulse_r[`PCPC_ABL_MSB:`PCPC_ABL_LSB];
    // step code n gives (n+1) x 600 uA nominal, code 7 is 4.8 mA
    cp_current_nxt = act_cp_current_r[`PCPC_CPI_MSB:`PCPC_CPI_LSB];
    cp_highz_nxt   = 1'b0;
    cp_normal_nxt  = 1'b0;
    cp_up_nxt      = 1'b0;
    cp_dn_nxt      = 1'b0;
    case (cp_mode)
      `PCPC_CPM_NORMAL:
      begin
        cp_normal_nxt = 1'b1;
      end
      `PCPC_CPM_UP:
      begin
        cp_up_nxt = 1'b1;
      end
      `PCPC_CPM_DN:
      begin
        cp_dn_nxt = 1'b1;
      end
      default:
      begin
        // unlisted mode codes fall back to high impedance (holdover)
        cp_highz_nxt = 1'b1;
      end
    endcase
  end

  // hardware control outputs, registered from the active copies
  always @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      PLL_ON_OUT       <= 1'b0;
      PLL_PWRDN_OUT    <= 1'b1;
      DIV_BYPASS_OUT   <= 1'b0;
      SRC_INT_VCO_OUT  <= 1'b0;
      SRC_EXT_CLK_OUT  <= 1'b1;
      PFD_POL_NEG_OUT  <= 1'b0;
      ANTIBACKLASH_OUT <= 2'h0;
      CP_HIGHZ_OUT     <= 1'b1;
      CP_NORMAL_OUT    <= 1'b0;
      CP_PUMP_UP_OUT   <= 1'b0;
      CP_PUMP_DN_OUT   <= 1'b0;
      CP_CURRENT_OUT   <= 3'h7;
      VCO_CAL_BUSY_OUT <= 1'b0;
    end
    else
    begin
      PLL_ON_OUT       <= pll_on_nxt;
      PLL_PWRDN_OUT    <= pll_pwrdn_nxt;
      DIV_BYPASS_OUT   <= div_bypass_nxt;
      SRC_INT_VCO_OUT  <= src_int_nxt;
      SRC_EXT_CLK_OUT  <= src_ext_nxt;
      PFD_POL_NEG_OUT  <= pol_neg_nxt;
      ANTIBACKLASH_OUT <= abl_nxt;
      CP_HIGHZ_OUT     <= cp_highz_nxt;
      CP_NORMAL_OUT    <= cp_normal_nxt;
      CP_PUMP_UP_OUT   <= cp_up_nxt;
      CP_PUMP_DN_OUT   <= cp_dn_nxt;
      CP_CURRENT_OUT   <= cp_current_nxt;
      VCO_CAL_BUSY_OUT <= (cal_state_nxt == ST_RUN);
    end
  end

endmodule // pcpc_top
`default_nettype wire

// ### tb.sv
// directed testbench for the pll clock path control block.
// assumes zero-wait apb and outputs moving one edge after a commit.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clk = 0;
  logic        rstn = 0;
  logic        psel = 0;
  logic        pen = 0;
  logic        pwr = 0;
  logic        ref_ok = 1;
  logic [11:0] addr = 0;
  logic [31:0] wdata = 0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready, pslverr, err, on, pdn, byp, intv, extc, pol, busy;
  logic        hz, nrm, up, dn;
  logic [1:0]  abl;
  logic [2:0]  cur;
  int          failures = 0;
  int          checks = 0;
  int          cyc = 0;
  int          n;
  always #20 clk = ~clk;
  pcpc_top #(.CAL_CYCLES(8)) u_pcpc_top (.CLK_IN(clk), .RSTN_IN(rstn),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(addr),
    .PWDATA_IN(wdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .REF_PRESENT_IN(ref_ok), .PLL_ON_OUT(on),
    .PLL_PWRDN_OUT(pdn), .DIV_BYPASS_OUT(byp), .SRC_INT_VCO_OUT(intv),
    .SRC_EXT_CLK_OUT(extc), .PFD_POL_NEG_OUT(pol), .ANTIBACKLASH_OUT(abl),
    .CP_HIGHZ_OUT(hz), .CP_NORMAL_OUT(nrm), .CP_PUMP_UP_OUT(up),
    .CP_PUMP_DN_OUT(dn), .CP_CURRENT_OUT(cur), .VCO_CAL_BUSY_OUT(busy));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel  <= 1'b1;
    pwr   <= w;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  // outputs follow one edge after the commit edge
  task automatic commit;
    apb(1, 12'h8c8, 32'h1);
    @(posedge clk);
    #1;
  endtask
  task automatic cal_run(input int exp_len);
    n = 0;
    while (busy === 1'b1 && n < 40)
    begin
      n++;
      @(posedge clk);
      #1;
    end
    chk(n, exp_len);
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      failures++;
      complete_run;
    end
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk({on, pdn, extc, hz, cur}, 7'h3f);
    apb(0, 12'h040, 0);
    chk(rd, 32'h1);
    apb(0, 12'h3c0, 0);
    chk(rd, 32'h7);
    // staged value must not reach the loop until committed
    apb(1, 12'h040, 32'h0);
    apb(1, 12'h8c8, 32'h2);
    repeat (2) @(posedge clk);
    chk(on, 0);
    commit;
    chk(on, 1);
    for (int i = 0; i < 8; i++)
    begin
      apb(1, 12'h040, {24'h0, 1'b1, i[2:0], 2'b00, i[1:0]});
      apb(1, 12'h05c, i[1:0]);
      apb(1, 12'h3c0, i[2:0]);
      commit;
      chk({on, pdn, pol, abl}, {i[1:0] == 0, i[1:0] != 0, 1'b1, i[1:0]});
      chk({hz, nrm, up, dn, cur}, {i == 0 || i > 3, i == 3, i == 1,
          i == 2, i[2:0]});
    end
    for (int s = 0; s < 4; s++)
    begin
      apb(1, 12'h784, s);
      commit;
      chk({byp, intv, extc, pol}, {s[0], s[1], !s[1], !s[1]});
    end
    apb(1, 12'h060, 32'h1);
    commit;
    cal_run(8);
    apb(0, 12'h3c4, 0);
    chk(rd[3:2], 2'b01);
    commit;
    chk(busy, 0);
    @(posedge clk);
    ref_ok <= 1'b0;
    apb(1, 12'h060, 32'h0);
    commit;
    apb(1, 12'h060, 32'h1);
    commit;
    cal_run(8);
    apb(0, 12'h3c4, 0);
    chk(rd[3], 1);
    apb(1, 12'h004, 32'hff);
    chk(err, 1);
    apb(0, 12'h041, 0);
    chk({err, rd}, {1'b1, 32'h0});
    apb(0, 12'h8c8, 0);
    chk(rd, 0);
    complete_run;
  end
endmodule // tb
`default_nettype wire
